//--- src/qbs_pkg.sv
// Summary of operation
// RL1: Read starts on low read select at K
// RL2: First read word two K rises later
// RL3: Remaining words on following K#, K edges
// RL4: Read right after read is ignored
// RL5: After reads finish, outputs float at K
// RL6: Write select low starts four-word write
// RL7: Write right after write is ignored
// RL8: Deselected write port ignores inputs after burst
// RL9: Byte selects sampled with every data word
// RL10: Read and write ports work independently
// RL11: Read after write returns newest data
// RL12: Both selected: previous start decides winner
// RL13: Both held: alternate, read first
// RL14: Controller starts one transaction per cycle
// RL15: Selects sampled at K; ports independent
// RL16: Impedance recalibration every 1024 cycles
// RL17: Free-running true and complement echo clocks
// RL18: Valid flag leads read data by half cycle
// RL19: PLL locks 20 us after stable clock
// RL20: Clock stopped 30 ns resets PLL
// RL21: PLL disabled gives one-cycle read latency
// RL22: Burst addresses A, A+1, A+2, A+3
// RL23: Powers up deselected, outputs floating
// RL24: Byte select 0 bits 8:0, 1 bits 17:9
package qbs_pkg;

	localparam int DATA_W          = 18;
	localparam int BYTE_W          = 9;
	localparam int BWS_W           = 2;
	localparam int BURST_LEN       = 4;
	localparam int BURST_ADDR_W    = 19;
	localparam int RD_LAT_PLL      = 2;
	localparam int RD_LAT_LEGACY   = 1;
	localparam int FIFO_DEPTH      = 32;
	localparam int CLK_PERIOD_NS   = 4;
	localparam int LOCK_TIME_US    = 20;
	localparam int LOCK_CYCLES_DEF = (LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STOP_TIME_NS    = 30;
	localparam int STOP_CYCLES     = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STOP_W          = $clog2(STOP_CYCLES + 2);
	localparam int CAL_PERIOD      = 1024;
	localparam int IDLE_W          = 4;

endpackage : qbs_pkg

//--- src/qbs_if.sv
`timescale 1ns/1ps
`default_nettype none
interface qbs_if
	import qbs_pkg::*;
#(
	parameter int AW = BURST_ADDR_W
) ();
	logic                input_clock;
	logic                read_port_select_n;
	logic                write_port_select_n;
	logic                pll_disable_n;
	logic [AW-1:0]       address;
	logic [DATA_W-1:0]   write_data;
	logic [BWS_W-1:0]    byte_write_select_n;
	logic [DATA_W-1:0]   read_data;
	logic                read_data_oe;
	logic                echo_clock;
	logic                echo_clock_n;
	logic                valid_data_flag;

	modport device (
		input  input_clock, read_port_select_n, write_port_select_n, pll_disable_n,
		input  address, write_data, byte_write_select_n,
		output read_data, read_data_oe, echo_clock, echo_clock_n, valid_data_flag
	);

	modport host (
		output input_clock, read_port_select_n, write_port_select_n, pll_disable_n,
		output address, write_data, byte_write_select_n,
		input  read_data, read_data_oe, echo_clock, echo_clock_n, valid_data_flag
	);
endinterface : qbs_if
`default_nettype wire

//--- src/qbs_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module qbs_fifo #(
	parameter int W     = 20,
	parameter int DEPTH = 32,
	parameter int LW    = $clog2(DEPTH + 1)
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          in_valid,
	output logic               in_ready,
	input  wire logic [W-1:0]  in_data,
	output logic               out_valid,
	input  wire logic          out_ready,
	output logic [W-1:0]       out_data,
	output logic [LW-1:0]      level
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [LW-1:0] cnt;
	} qbs_fifo_st_t;

	qbs_fifo_st_t     s_q;
	qbs_fifo_st_t     s_d;
	logic [W-1:0]     mem [DEPTH];
	logic             push;
	logic             pop;

	assign in_ready  = (s_q.cnt != LW'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign out_data  = mem[s_q.rp];
	assign level     = s_q.cnt;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.wp = s_q.wp + PW'(1);
		end
		if (pop) begin
			s_d.rp = s_q.rp + PW'(1);
		end
		s_d.cnt = s_q.cnt + LW'(push) - LW'(pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[s_q.wp] <= in_data;
		end
	end
endmodule : qbs_fifo
`default_nettype wire

//--- src/qbs_host.sv
`timescale 1ns/1ps
`default_nettype none
module qbs_host
	import qbs_pkg::*;
#(
	parameter int AW          = BURST_ADDR_W,
	parameter int LOCK_CYCLES = LOCK_CYCLES_DEF
) (
	input  wire logic               CLOCK,
	input  wire logic               RESET_N,
	qbs_if.host                     LINK,
	input  wire logic               PLL_DISABLE_N,
	input  wire logic               PLL_RESET,
	input  wire logic               CMD_VALID,
	input  wire logic               CMD_WRITE,
	input  wire logic [AW-1:0]      CMD_ADDR,
	output logic                    CMD_READY,
	input  wire logic               WR_VALID,
	input  wire logic [DATA_W-1:0]  WR_DATA,
	input  wire logic [BWS_W-1:0]   WR_BYTE_SEL_N,
	output logic                    WR_READY,
	output logic                    RD_VALID,
	output logic [DATA_W-1:0]       RD_DATA,
	output logic                    LINK_READY
);
	localparam int LW = $clog2(LOCK_CYCLES + 1);
	localparam int FW = DATA_W + BWS_W;
	localparam int QW = $clog2(FIFO_DEPTH + 1);

	typedef struct packed {
		logic               k;
		logic               pll_n;
		logic [STOP_W-1:0]  stop_cnt;
		logic [LW-1:0]      lock_cnt;
		logic               locked;
		logic               rsel_n;
		logic               wsel_n;
		logic [AW-1:0]      addr;
		logic               last_rd;
		logic               last_wr;
		logic [4:0]         pop_sr;
		logic [DATA_W-1:0]  wd;
		logic [BWS_W-1:0]   bws_n;
		logic               vld_prev;
		logic               rd_v;
		logic [DATA_W-1:0]  rd;
		logic [IDLE_W-1:0]  idle;
	} qbs_host_st_t;

	qbs_host_st_t       s_q;
	qbs_host_st_t       s_d;
	logic               f_valid;
	logic [FW-1:0]      f_data;
	logic [QW-1:0]      f_level;
	logic [QW-1:0]      avail;
	logic               dec;
	logic               issue;

	qbs_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_wfifo (
		.clk       (CLOCK),
		.rst_n     (RESET_N),
		.in_valid  (WR_VALID),
		.in_ready  (WR_READY),
		.in_data   ({WR_BYTE_SEL_N, WR_DATA}),
		.out_valid (f_valid),
		.out_ready (s_q.pop_sr[0]),
		.out_data  (f_data),
		.level     (f_level)
	);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Next cycle is a K rise when the clock runs and K is low now
	assign dec   = ~s_q.k & (s_q.stop_cnt == '0);
	assign avail = f_level - QW'($countones(s_q.pop_sr));
	// RL14 one start only
	assign CMD_READY = dec & s_q.locked & (CMD_WRITE ?
		(~s_q.last_wr & (avail >= QW'(BURST_LEN)) & f_valid) : ~s_q.last_rd);
	assign issue = CMD_VALID & CMD_READY;

	always_comb begin
		s_d = s_q;
		s_d.pll_n = PLL_DISABLE_N;
		s_d.rsel_n = 1'b1;
		s_d.wsel_n = 1'b1;
		// RL4 RL7 spacing kept
		if (dec) begin
			s_d.last_rd = issue & ~CMD_WRITE;
			s_d.last_wr = issue & CMD_WRITE;
		end
		// RL1 RL6 start request
		if (issue) begin
			s_d.addr = CMD_ADDR;
			s_d.rsel_n = CMD_WRITE;
			s_d.wsel_n = ~CMD_WRITE;
		end
		// Data words leave on four edges, beginning two edges after the start
		s_d.pop_sr = {1'b0, s_q.pop_sr[4:1]} | ((issue & CMD_WRITE) ? 5'h1e : 5'h00);
		s_d.bws_n = '1;
		// RL9 mask with each word
		if (s_q.pop_sr[0]) begin
			s_d.wd = f_data[DATA_W-1:0];
			s_d.bws_n = f_data[FW-1:DATA_W];
		end
		// RL18 capture behind flag
		s_d.vld_prev = LINK.valid_data_flag;
		s_d.rd_v = s_q.vld_prev;
		if (s_q.vld_prev) begin
			s_d.rd = LINK.read_data;
		end
		if (issue) begin
			s_d.idle = '0;
		end else if (s_q.idle != '1) begin
			s_d.idle = s_q.idle + IDLE_W'(1);
		end
		// RL20 stop clock to reset
		if (s_q.stop_cnt != '0) begin
			s_d.k = 1'b1;
			s_d.stop_cnt = s_q.stop_cnt - STOP_W'(1);
			s_d.locked = 1'b0;
			s_d.lock_cnt = '0;
		end else begin
			s_d.k = ~s_q.k;
			if (PLL_RESET & s_q.pll_n & (s_q.idle == '1) & ~issue) begin
				s_d.stop_cnt = STOP_W'(STOP_CYCLES + 1);
			end
			// RL19 wait for lock
			if (~s_q.pll_n) begin
				s_d.locked = 1'b1;
			end else if (~s_q.locked) begin
				s_d.lock_cnt = s_q.lock_cnt + LW'(1);
				s_d.locked = (s_q.lock_cnt == LW'(LOCK_CYCLES - 1));
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_q <= '{rsel_n: 1'b1, wsel_n: 1'b1, bws_n: '1, pll_n: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	assign LINK.input_clock         = s_q.k;
	assign LINK.read_port_select_n  = s_q.rsel_n;
	assign LINK.write_port_select_n = s_q.wsel_n;
	assign LINK.pll_disable_n       = s_q.pll_n;
	assign LINK.address             = s_q.addr;
	assign LINK.write_data          = s_q.wd;
	assign LINK.byte_write_select_n = s_q.bws_n;
	assign RD_VALID                 = s_q.rd_v;
	assign RD_DATA                  = s_q.rd;
	assign LINK_READY               = s_q.locked;
endmodule : qbs_host
`default_nettype wire

//--- src/qbs_device.sv
`timescale 1ns/1ps
`default_nettype none
module qbs_device
	import qbs_pkg::*;
#(
	parameter int AW          = BURST_ADDR_W,
	parameter int LOCK_CYCLES = LOCK_CYCLES_DEF
) (
	input  wire logic  CLOCK,
	input  wire logic  RESET_N,
	qbs_if.device      LINK,
	output logic       PLL_LOCKED,
	output logic       IMPEDANCE_CAL
);
	localparam int LW    = $clog2(LOCK_CYCLES + 1);
	localparam int CW    = $clog2(CAL_PERIOD);
	localparam int WORDS = 1 << (AW + 2);

	typedef struct packed {
		logic               k_prev;
		logic               last_rd;
		logic               last_wr;
		logic [2:0]         rsr;
		logic [AW-1:0]      r_addr;
		logic               b_on;
		logic [1:0]         b_idx;
		logic [AW-1:0]      b_base;
		logic [4:0]         wsr;
		logic [AW-1:0]      w_cur;
		logic [AW-1:0]      w_prev;
		logic [DATA_W-1:0]  q;
		logic               oe;
		logic               vld;
		logic               echo;
		logic [STOP_W-1:0]  stop_cnt;
		logic [LW-1:0]      lock_cnt;
		logic               locked;
		logic [CW-1:0]      cal_cnt;
		logic               cal;
	} qbs_dev_st_t;

	qbs_dev_st_t        s_q;
	qbs_dev_st_t        s_d;
	logic [DATA_W-1:0]  mem [WORDS];
	logic               kr;
	logic               legacy;
	logic               rd_ok;
	logic               wr_ok;
	logic               rd_start;
	logic               wr_start;
	logic               launch;
	logic               pre;
	logic               reading;
	logic [AW-1:0]      r_base;
	logic [1:0]         r_idx;
	logic               w_en;
	logic [AW-1:0]      w_base;
	logic [1:0]         w_idx;

	// RL22 sequential burst word
	function automatic logic [AW+1:0] word_addr(input logic [AW-1:0] base,
		input logic [1:0] idx);
		word_addr = {base, idx};
	endfunction : word_addr

	////////////////////////////////////////////////////////////////////////////////////////////
	// Start decode
	always_comb begin
		// RL15 sampled at K only
		kr = LINK.input_clock & ~s_q.k_prev;
		// RL21 legacy latency mode
		legacy = ~LINK.pll_disable_n;
		// RL4 drop repeated read
		rd_ok = kr & ~LINK.read_port_select_n & ~s_q.last_rd;
		// RL7 drop repeated write
		wr_ok = kr & ~LINK.write_port_select_n & ~s_q.last_wr;
		// RL12 RL13 read wins unless
		rd_start = rd_ok;
		wr_start = wr_ok & ~rd_ok;
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Read and write pipelines
	always_comb begin
		s_d = s_q;
		s_d.k_prev = LINK.input_clock;
		if (kr) begin
			s_d.last_rd = rd_start;
			s_d.last_wr = wr_start;
		end
		// RL1 latch read address
		if (rd_start) begin
			s_d.r_addr = LINK.address;
		end
		s_d.rsr = {s_q.rsr[1:0], rd_start};
		// RL2 RL21 first word timing
		launch = legacy ? s_q.rsr[2*RD_LAT_LEGACY-2] : s_q.rsr[2*RD_LAT_PLL-2];
		pre = legacy ? rd_start : s_q.rsr[2*RD_LAT_PLL-3];
		r_base = s_q.b_base;
		r_idx = s_q.b_idx;
		// RL3 words on both edges
		if (launch) begin
			r_base = s_q.r_addr;
			r_idx = 2'h0;
			s_d.b_on = 1'b1;
			s_d.b_base = s_q.r_addr;
			s_d.b_idx = 2'h1;
		end else if (s_q.b_on) begin
			s_d.b_idx = s_q.b_idx + 2'h1;
			s_d.b_on = (s_q.b_idx != 2'h3);
		end
		reading = launch | s_q.b_on;
		// RL11 array already holds newest
		if (reading) begin
			s_d.q = mem[word_addr(r_base, r_idx)];
		end
		// RL5 float after next K
		s_d.oe = reading | (s_q.oe & kr);
		// RL18 flag half cycle early
		s_d.vld = pre | launch | (s_q.b_on & (s_q.b_idx != 2'h3));
		// RL6 write address latch
		s_d.wsr = {s_q.wsr[3:0], wr_start};
		if (wr_start) begin
			s_d.w_prev = s_q.w_cur;
			s_d.w_cur = LINK.address;
		end
		// RL17 echo follows input clock
		if (LINK.input_clock != s_q.k_prev) begin
			s_d.echo = ~LINK.input_clock;
		end
		// RL20 stopped clock detect
		if (LINK.input_clock == s_q.k_prev) begin
			if (s_q.stop_cnt != STOP_W'(STOP_CYCLES)) begin
				s_d.stop_cnt = s_q.stop_cnt + STOP_W'(1);
			end
		end else begin
			s_d.stop_cnt = '0;
		end
		// RL19 lock after stable clock
		if (legacy) begin
			s_d.locked = 1'b1;
			s_d.lock_cnt = '0;
		end else if (s_q.stop_cnt == STOP_W'(STOP_CYCLES)) begin
			s_d.locked = 1'b0;
			s_d.lock_cnt = '0;
		end else if (~s_q.locked) begin
			s_d.lock_cnt = s_q.lock_cnt + LW'(1);
			s_d.locked = (s_q.lock_cnt == LW'(LOCK_CYCLES - 1));
		end
		// RL16 periodic impedance update
		s_d.cal = 1'b0;
		if (kr) begin
			s_d.cal_cnt = s_q.cal_cnt + CW'(1);
			s_d.cal = (s_q.cal_cnt == CW'(CAL_PERIOD - 1));
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Write data capture
	always_comb begin
		// RL6 RL8 words only in burst
		w_en = |s_q.wsr[4:1];
		w_idx = {s_q.wsr[4] | s_q.wsr[3], s_q.wsr[4] | s_q.wsr[2]};
		// RL10 overlapping bursts kept apart
		w_base = s_q.wsr[0] ? s_q.w_prev : s_q.w_cur;
	end

	always_ff @(posedge CLOCK) begin
		// RL9 RL24 byte masking
		if (w_en & ~LINK.byte_write_select_n[0]) begin
			mem[word_addr(w_base, w_idx)][BYTE_W-1:0] <= LINK.write_data[BYTE_W-1:0];
		end
		if (w_en & ~LINK.byte_write_select_n[1]) begin
			mem[word_addr(w_base, w_idx)][DATA_W-1:BYTE_W] <= LINK.write_data[DATA_W-1:BYTE_W];
		end
	end

	// RL23 deselected floating at reset
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	assign LINK.read_data       = s_q.q;
	assign LINK.read_data_oe    = s_q.oe;
	assign LINK.valid_data_flag = s_q.vld;
	assign LINK.echo_clock      = s_q.echo;
	assign LINK.echo_clock_n    = ~s_q.echo;
	assign PLL_LOCKED           = s_q.locked;
	assign IMPEDANCE_CAL        = s_q.cal;
endmodule : qbs_device
`default_nettype wire

//--- verif/qbs_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module qbs_link_props (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic input_clock,
	input wire logic read_port_select_n,
	input wire logic write_port_select_n,
	input wire logic pll_disable_n,
	input wire logic read_data_oe,
	input wire logic echo_clock,
	input wire logic echo_clock_n,
	input wire logic valid_data_flag
);
	logic k_q;
	logic k_slot;
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) k_q <= 1'b0;
		else k_q <= input_clock;
	end
	assign k_slot = input_clock & ~k_q;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	////////////////////////////////////////////////////////////////
	sequence rd_go; k_slot && !read_port_select_n; endsequence
	sequence wr_go; k_slot && !write_port_select_n; endsequence
	sequence k_toggle; k_q != input_clock; endsequence
	a_rd_oe_pll: assert property (rd_go ##0 pll_disable_n |-> ##4 read_data_oe [*4])
		else $error("read data window wrong");
	a_rd_vld_pll: assert property (rd_go ##0 pll_disable_n |-> ##3 valid_data_flag [*4])
		else $error("valid flag window wrong");
	a_rd_oe_legacy: assert property (rd_go ##0 !pll_disable_n |-> ##2 read_data_oe [*4])
		else $error("legacy read window wrong");
	a_rd_spacing: assert property (rd_go |=> (!k_slot || read_port_select_n) [*3])
		else $error("reads too close");
	a_wr_spacing: assert property (wr_go |=> (!k_slot || write_port_select_n) [*3])
		else $error("writes too close");
	a_one_start: assert property (!(!read_port_select_n && !write_port_select_n))
		else $error("two starts in one cycle");
	a_echo_pair: assert property (echo_clock_n == ~echo_clock)
		else $error("echo clocks not complementary");
	a_echo_follow: assert property (k_toggle ##1 k_toggle |-> echo_clock == input_clock)
		else $error("echo clock not following input clock");
	a_oe_release: assert property ($fell(read_data_oe) |-> k_slot)
		else $error("outputs released off a K rise");
	a_vld_leads: assert property ($rose(read_data_oe) |-> $past(valid_data_flag))
		else $error("valid flag not ahead of data");
endmodule : qbs_link_props
`default_nettype wire

//--- verif/quad_rate_burst_sram_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none
module quad_rate_burst_sram_ports_tb;
	import qbs_pkg::*;
	localparam int AW = BURST_ADDR_W;
	logic             CLOCK = 1'b0;
	logic             RESET_N = 1'b0;
	logic             pll_dis_n = 1'b1;
	logic             cmd_valid = 1'b0;
	logic             cmd_write = 1'b0;
	logic [AW-1:0]    cmd_addr = '0;
	logic             wr_valid = 1'b0;
	logic [17:0]      wr_data = '0;
	logic [1:0]       wr_bs = 2'h3;
	logic             cmd_ready, wr_ready, rd_valid, link_ready;
	logic             pll_rst = 1'b0;
	logic             dev_locked, dev_cal;
	logic             kp = 1'b0;
	int               kc = 0;
	int               cal_seen = 0;
	logic [17:0]      rd_data;
	int               err_total = 0;
	int               cmp_count = 0;
	logic [31:0]      rs = 32'h0001_0799;
	logic [17:0]      mem [logic [AW+1:0]];
	logic [19:0]      wq [$];
	logic [17:0]      rq [$];
	logic [AW-1:0]    aq [$];
	logic [AW-1:0]    a;
	always #2 CLOCK = ~CLOCK;
	////////////////////////////////////////////////////////////////
	qbs_if #(.AW(AW)) link ();
	qbs_host #(.AW(AW), .LOCK_CYCLES(20)) u_qbs_host (.CLOCK(CLOCK), .RESET_N(RESET_N),
		.LINK(link), .PLL_DISABLE_N(pll_dis_n), .PLL_RESET(pll_rst), .CMD_VALID(cmd_valid),
		.CMD_WRITE(cmd_write), .CMD_ADDR(cmd_addr), .CMD_READY(cmd_ready),
		.WR_VALID(wr_valid), .WR_DATA(wr_data), .WR_BYTE_SEL_N(wr_bs), .WR_READY(wr_ready),
		.RD_VALID(rd_valid), .RD_DATA(rd_data), .LINK_READY(link_ready));
	qbs_device #(.AW(AW), .LOCK_CYCLES(20)) u_qbs_device (.CLOCK(CLOCK), .RESET_N(RESET_N),
		.LINK(link), .PLL_LOCKED(dev_locked), .IMPEDANCE_CAL(dev_cal));
	qbs_link_props u_qbs_link_props (.CLOCK(CLOCK), .RESET_N(RESET_N),
		.input_clock(link.input_clock), .read_port_select_n(link.read_port_select_n),
		.write_port_select_n(link.write_port_select_n), .pll_disable_n(link.pll_disable_n),
		.read_data_oe(link.read_data_oe), .echo_clock(link.echo_clock),
		.echo_clock_n(link.echo_clock_n), .valid_data_flag(link.valid_data_flag));
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xs
	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic give_verdict();
		if (err_total == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict
	function automatic bit rdy(input int s);
		case (s)
			0: return wr_ready === 1'b1;
			1: return cmd_ready === 1'b1;
			2: return link_ready === 1'b1;
			3: return rq.size() == 0;
			default: return link_ready === 1'b0;
		endcase
	endfunction : rdy
	task automatic wait_rdy(input int s);
		int n;
		n = 0;
		forever begin
			@(negedge CLOCK);
			if (rdy(s)) break;
			if (++n > 400) begin
				err_total++;
				$display("ERROR %0t: wait %0d timed out", $time, s);
				give_verdict();
			end
		end
		@(posedge CLOCK);
	endtask : wait_rdy
	task automatic push4(input logic [7:0] m);
		logic [17:0] d;
		for (int j = 0; j < 4; j++) begin
			d = 18'(xs());
			wr_valid <= 1'b1;
			wr_data <= d;
			wr_bs <= m[2*j+:2];
			wait_rdy(0);
			wq.push_back({m[2*j+:2], d});
		end
		wr_valid <= 1'b0;
		@(posedge CLOCK);
	endtask : push4
	task automatic cmd(input bit w, input logic [AW-1:0] ad);
		logic [19:0] e;
		logic [AW+1:0] k;
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_addr <= ad;
		wait_rdy(1);
		cmd_valid <= 1'b0;
		for (int i = 0; i < BURST_LEN; i++) begin
			k = {ad, 2'(i)};
			if (w) begin
				e = wq.pop_front();
				if (!e[18]) mem[k][8:0] = e[8:0];
				if (!e[19]) mem[k][17:9] = e[17:9];
			end else rq.push_back(mem[k]);
		end
		@(posedge CLOCK);
	endtask : cmd
	////////////////////////////////////////////////////////////////
	always @(negedge CLOCK) begin
		if (!RESET_N) begin
			kc = 0;
			kp = 1'b0;
		end else begin
			if (rd_valid === 1'b1)
				check(rd_data, rq.size() > 0 ? rq.pop_front() : ~rd_data);
			if (dev_cal === 1'b1) begin
				cal_seen++;
				check(18'(kc), 18'(CAL_PERIOD));
				kc = 0;
			end
			if (link.input_clock === 1'b1 && kp === 1'b0) kc++;
			kp = link.input_clock;
		end
	end
	initial begin
		repeat (10) @(posedge CLOCK);
		check({17'h0, link.read_data_oe}, 18'h0);
		check({16'h0, link.read_port_select_n, link.write_port_select_n}, 18'h3);
		RESET_N <= 1'b1;
		wait_rdy(2);
		@(negedge CLOCK);
		check({17'h0, dev_locked}, 18'h1);
		@(posedge CLOCK);
		// Masked rewrite, forwarded read, interleaved older read
		for (int i = 1; i < 13; i++) begin
			a = AW'(i * 8 + (xs() & 3));
			aq.push_back(a);
			push4(8'h00);
			cmd(1, a);
			push4(i == 1 ? 8'h1b : 8'(xs()));
			cmd(1, a);
			cmd(0, a);
			cmd(0, aq[xs() % aq.size()]);
		end
		// Fill buffer until it refuses, then drain through writes
		for (int i = 0; i < 8; i++) push4(8'h00);
		@(negedge CLOCK);
		check({17'h0, wr_ready}, 18'h0);
		@(posedge CLOCK);
		for (int i = 0; i < 8; i++) cmd(1, AW'(200 + i * 8));
		for (int i = 0; i < 8; i += 3) cmd(0, AW'(200 + i * 8));
		wait_rdy(3);
		check({17'h0, wr_ready}, 18'h1);
		// Long idle for impedance pulses, then a clock stop and relock
		repeat (2100) @(posedge CLOCK);
		check({17'h0, cal_seen != 0}, 18'h1);
		pll_rst <= 1'b1;
		wait_rdy(4);
		pll_rst <= 1'b0;
		repeat (12) @(posedge CLOCK);
		@(negedge CLOCK);
		check({17'h0, dev_locked}, 18'h0);
		@(posedge CLOCK);
		wait_rdy(2);
		repeat (4) @(posedge CLOCK);
		@(negedge CLOCK);
		check({17'h0, dev_locked}, 18'h1);
		@(posedge CLOCK);
		// Legacy latency mode after a fresh reset
		pll_dis_n <= 1'b0;
		RESET_N <= 1'b0;
		repeat (10) @(posedge CLOCK);
		RESET_N <= 1'b1;
		wait_rdy(2);
		@(negedge CLOCK);
		check({17'h0, dev_locked}, 18'h1);
		@(posedge CLOCK);
		push4(8'h00);
		cmd(1, AW'(1024));
		cmd(0, AW'(1024));
		wait_rdy(3);
		give_verdict();
	end
endmodule : quad_rate_burst_sram_ports_tb
`default_nettype wire
